/* File: src/wake_watchdog_reset_sequencer.sv */
// Wake tick generator, watchdog monitor and reset sequencer
`timescale 1ns/100ps
`default_nettype none
module wake_watchdog_reset_sequencer
	import wake_wd_pkg::*;
#(
	parameter int WAKE_PERIOD = WAKE_PERIOD_CYC,
	parameter int RESET_DELAY = RESET_DELAY_CYC
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic ARST_N,
	// Regulation status from analog side
	input wire logic OUTPUT_IN_REG,
	// Processor side
	input wire logic WATCHDOG_INPUT,
	output logic WAKE_TICK,
	output logic RESET_N
);
	import wake_wd_pkg::*;

	localparam int HALF = WAKE_PERIOD / 2;
	// One full tick period, high half plus low half
	localparam int FULL = 2 * HALF;

	seq_state_t state, next_state;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic seen, next_seen;
	logic wd_fall;

	wd_edge_sync u_sync (
		.clk(CLK),
		.arst_n(ARST_N),
		.din(WATCHDOG_INPUT),
		.fall(wd_fall)
	);

	wire half_done = cnt == CNT_W'(HALF - 1);
	wire delay_done = cnt == CNT_W'(RESET_DELAY - 1);
	wire first_edge = wd_fall & ~seen & (state == ST_HIGH || state == ST_LOW);
	wire cycle_end = (state == ST_LOW) & half_done;
	// An edge caught in the very last cycle still counts for this cycle
	wire missed = cycle_end & ~(seen | first_edge);

	// Next-state logic; regulation loss overrides every state

	always_comb begin
		next_state = state;
		next_cnt = cnt + CNT_W'(1);
		next_seen = seen | first_edge;
		case (state)
			// Reset held; delay counts only while in regulation
			ST_HOLD: begin
				next_seen = 1'b0;
				if (!OUTPUT_IN_REG) begin
					next_cnt = '0;
				end else if (delay_done) begin
					next_state = ST_DELAY;
					next_cnt = '0;
				end
			end
			// Reset released; tick held low for half a period
			ST_DELAY: begin
				next_seen = 1'b0;
				if (half_done) begin
					next_state = ST_HIGH;
					next_cnt = '0;
				end
			end
			// High half of the tick
			ST_HIGH: begin
				if (half_done) begin
					next_state = ST_LOW;
					next_cnt = '0;
				end
			end
			// Low half; the cycle is judged at its end
			ST_LOW: begin
				if (half_done) begin
					next_state = missed ? ST_HOLD : ST_HIGH;
					next_seen = 1'b0;
					next_cnt = '0;
				end
			end
			default: begin
				next_state = ST_HOLD;
				next_cnt = '0;
			end
		endcase
		if (!OUTPUT_IN_REG) begin
			next_state = ST_HOLD;
			next_cnt = '0;
			next_seen = 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state <= ST_HOLD;
			cnt <= '0;
			seen <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			seen <= next_seen;
		end
	end

	// Outputs registered from next-state values
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			RESET_N <= 1'b0;
			WAKE_TICK <= 1'b0;
		end else begin
			RESET_N <= next_state != ST_HOLD;
			WAKE_TICK <= next_state == ST_HIGH && !next_seen;
		end
	end

	// Run-length monitors; they feed only the timing assertions below
	logic [CNT_W-1:0] high_run;
	logic [CNT_W-1:0] idle_run;
	logic [CNT_W-1:0] low_run;
	logic [CNT_W-1:0] up_run;
	logic [CNT_W-1:0] per_run;
	logic tick_d;
	wire tick_rise = WAKE_TICK & ~tick_d;
	// Counters saturate so a long power-up hold cannot wrap them
	wire [CNT_W-1:0] high_step = (&high_run) ? high_run : high_run + CNT_W'(1);
	wire [CNT_W-1:0] idle_step = (&idle_run) ? idle_run : idle_run + CNT_W'(1);
	wire [CNT_W-1:0] low_step = (&low_run) ? low_run : low_run + CNT_W'(1);
	wire [CNT_W-1:0] up_step = (&up_run) ? up_run : up_run + CNT_W'(1);
	wire [CNT_W-1:0] per_step = (&per_run) ? per_run : per_run + CNT_W'(1);
	// Cycles of tick high, tick low, reset low, reset high, since last rise
	wire [CNT_W-1:0] next_high_run = WAKE_TICK ? high_step : '0;
	wire [CNT_W-1:0] next_idle_run = WAKE_TICK ? '0 : idle_step;
	wire [CNT_W-1:0] next_low_run = RESET_N ? '0 : low_step;
	wire [CNT_W-1:0] next_up_run = RESET_N ? up_step : '0;
	wire [CNT_W-1:0] next_per_run = tick_rise ? CNT_W'(1) : per_step;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			high_run <= '0;
			idle_run <= '0;
			low_run <= '0;
			up_run <= '0;
			per_run <= '0;
			tick_d <= 1'b0;
		end else begin
			high_run <= next_high_run;
			idle_run <= next_idle_run;
			low_run <= next_low_run;
			up_run <= next_up_run;
			per_run <= next_per_run;
			tick_d <= WAKE_TICK;
		end
	end

	// Timing checks on the tick and the reset pulse
	a_high_max: assert property (@(posedge CLK) disable iff (!ARST_N)
		WAKE_TICK |-> high_run < CNT_W'(HALF))
		else $error("tick high too long");
	a_high_full: assert property (@(posedge CLK) disable iff (!ARST_N)
		$fell(WAKE_TICK) && RESET_N && !seen |-> high_run == CNT_W'(HALF))
		else $error("tick high half wrong length");
	a_low_min: assert property (@(posedge CLK) disable iff (!ARST_N)
		$rose(WAKE_TICK) |-> idle_run >= CNT_W'(HALF))
		else $error("tick low half too short");
	a_tick_period: assert property (@(posedge CLK) disable iff (!ARST_N)
		tick_rise && up_run > CNT_W'(FULL) |-> per_run == CNT_W'(FULL))
		else $error("tick period wrong");
	a_pulse_len: assert property (@(posedge CLK) disable iff (!ARST_N)
		$rose(RESET_N) |-> low_run >= CNT_W'(RESET_DELAY))
		else $error("reset pulse too short");
	a_wake_delay: assert property (@(posedge CLK) disable iff (!ARST_N)
		$rose(WAKE_TICK) |-> up_run >= CNT_W'(HALF))
		else $error("first tick too early");
	a_rise_up: assert property (@(posedge CLK) disable iff (!ARST_N)
		tick_rise |-> RESET_N)
		else $error("tick rose during reset");

	// Functional rule checks
	a_tick_low_reset: assert property (@(posedge CLK) disable iff (!ARST_N)
		!RESET_N |-> !WAKE_TICK) else $error("wake tick high during reset");
	a_edge_drops: assert property (@(posedge CLK) disable iff (!ARST_N)
		first_edge |=> !WAKE_TICK) else $error("wake tick not dropped");
	a_miss_reset: assert property (@(posedge CLK) disable iff (!ARST_N)
		missed && OUTPUT_IN_REG |=> !RESET_N) else $error("missed edge gave no reset");
	a_reg_loss: assert property (@(posedge CLK) disable iff (!ARST_N)
		!OUTPUT_IN_REG |=> !RESET_N) else $error("reset high without regulation");
	a_no_early: assert property (@(posedge CLK) disable iff (!ARST_N)
		$fell(RESET_N) && $past(OUTPUT_IN_REG) |-> $past(missed)) else $error("early reset");
	a_delay_start: assert property (@(posedge CLK) disable iff (!ARST_N)
		$rose(RESET_N) |-> !WAKE_TICK [*8]) else $error("tick too soon after reset");
	a_stays_low: assert property (@(posedge CLK) disable iff (!ARST_N)
		seen && state == ST_HIGH |-> !WAKE_TICK) else $error("tick rose after edge");
	a_restart: assert property (@(posedge CLK) disable iff (!ARST_N)
		$rose(RESET_N) |-> state == ST_DELAY && cnt == '0) else $error("no restart");

	c_tick: cover property (@(posedge CLK) disable iff (!ARST_N) $rose(WAKE_TICK));
	c_kick: cover property (@(posedge CLK) disable iff (!ARST_N) first_edge);
	c_miss: cover property (@(posedge CLK) disable iff (!ARST_N) missed);
	c_reg_loss: cover property (@(posedge CLK) disable iff (!ARST_N) $fell(OUTPUT_IN_REG));
	c_extra_kick: cover property (@(posedge CLK) disable iff (!ARST_N) wd_fall && seen);
endmodule : wake_watchdog_reset_sequencer
`default_nettype wire

/* File: src/wake_wd_pkg.sv */
// Timing constants and state codes for the wake tick and reset sequencer
package wake_wd_pkg;
	localparam int CLK_HZ = 10000000;
	localparam real WAKE_PERIOD_MS = 25.0;
	localparam real RESET_DELAY_MS = 3.0;
	localparam int WAKE_PERIOD_CYC = int'(WAKE_PERIOD_MS * CLK_HZ / 1000.0);
	localparam int HALF_PERIOD_CYC = WAKE_PERIOD_CYC / 2;
	localparam int RESET_DELAY_CYC = int'(RESET_DELAY_MS * CLK_HZ / 1000.0);
	localparam int CNT_W = 24;
	localparam int SYNC_STAGES = 2;
	typedef enum logic [3:0] {
		ST_HOLD = 4'h1,
		ST_DELAY = 4'h2,
		ST_HIGH = 4'h4,
		ST_LOW = 4'h8
	} seq_state_t;
endpackage : wake_wd_pkg

/* File: src/wd_edge_sync.sv */
// Synchroniser and falling edge detector for the watchdog input
`timescale 1ns/100ps
`default_nettype none
module wd_edge_sync
	import wake_wd_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic din,
	output logic fall
);
	logic [SYNC_STAGES:0] sh;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sh <= '1;
		end else begin
			sh <= {sh[SYNC_STAGES-1:0], din};
		end
	end
	// Stage 0 feeds only stage 1; edge seen between stages 1 and 2
	assign fall = sh[SYNC_STAGES] & ~sh[SYNC_STAGES-1];
endmodule : wd_edge_sync
`default_nettype wire

/* File: tb/mcu_model.sv */
// Processor model answering wake ticks with watchdog pulses
`timescale 1ns/100ps
`default_nettype none
module mcu_model (
	input wire logic clk,
	input wire logic wake,
	input wire logic [1:0] mode,
	output logic dog
);
	logic wake_d = 1'b0;
	initial dog = 1'b1;
	always @(negedge clk) begin
		wake_d <= wake;
		if (wake && !wake_d && mode != 2'h0) begin
			repeat (10) @(negedge clk);
			repeat (mode) begin
				dog <= 1'b0;
				repeat (50) @(negedge clk);
				dog <= 1'b1;
				repeat (40) @(negedge clk);
			end
		end
	end
endmodule : mcu_model
`default_nettype wire

/* File: tb/test_wake_watchdog_reset_sequencer.sv */
// Self-checking bench for the wake tick and reset sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
$display("[ERR] %0t mismatch", $time); end end
module test_wake_watchdog_reset_sequencer;
	localparam int WP = 200;
	localparam int RD = 20;
	localparam int HP = WP / 2;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic in_reg = 1'b0;
	logic [1:0] mode = 2'h0;
	wire dog, wake, rst_n;
	int num_errors = 0;
	int n_compared = 0;
	int n;
	always #50 clk = ~clk;
	mcu_model u_mcu (.clk(clk), .wake(wake), .mode(mode), .dog(dog));
	wake_watchdog_reset_sequencer #(.WAKE_PERIOD(WP), .RESET_DELAY(RD)) u_dut (
		.CLK(clk), .ARST_N(arst_n), .OUTPUT_IN_REG(in_reg),
		.WATCHDOG_INPUT(dog), .WAKE_TICK(wake), .RESET_N(rst_n));
	// Cycles until the chosen output reaches a level
	task automatic wt(input bit s, input logic v);
		n = 0;
		while (((s ? rst_n : wake) !== v) && n < 2000) begin
			@(negedge clk);
			n++;
		end
	endtask : wt
	task automatic close_out;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	task automatic t_power;
		repeat (40) @(negedge clk);
		`CHK(rst_n, 1'b0)
		in_reg = 1'b1;
		wt(1, 1'b1);
		`CHK(n >= RD && n <= RD + 3, 1'b1)
		wt(0, 1'b1);
		`CHK(n >= HP - 2 && n <= HP + 2, 1'b1)
	endtask : t_power
	task automatic t_miss;
		wt(0, 1'b0);
		`CHK(n >= HP - 2 && n <= HP + 2, 1'b1)
		wt(1, 1'b0);
		`CHK(n >= HP - 2 && n <= HP + 3, 1'b1)
		`CHK(wake, 1'b0)
		wt(1, 1'b1);
		`CHK(n >= RD - 1 && n <= RD + 3, 1'b1)
		`CHK(wake, 1'b0)
	endtask : t_miss
	task automatic t_resp(input logic [1:0] m);
		mode = m;
		wt(0, 1'b1);
		`CHK(n >= HP - 2 && n <= HP + 2, 1'b1)
		repeat (3) begin
			wt(0, 1'b0);
			`CHK(n >= 12 && n <= 20, 1'b1)
			wt(0, 1'b1);
			`CHK(n >= WP - 22 && n <= WP - 10, 1'b1)
			`CHK(rst_n, 1'b1)
		end
	endtask : t_resp
	task automatic t_uv;
		in_reg = 1'b0;
		repeat (3) @(negedge clk);
		`CHK({rst_n, wake}, 2'h0)
		repeat (200) @(negedge clk);
		`CHK(rst_n, 1'b0)
		in_reg = 1'b1;
		wt(1, 1'b1);
		`CHK(n >= RD && n <= RD + 3, 1'b1)
	endtask : t_uv
	initial begin
		repeat (6) @(negedge clk);
		arst_n = 1'b1;
		t_power();
		t_miss();
		t_resp(2'h1);
		t_uv();
		t_resp(2'h2);
		t_uv();
		t_resp(2'h1);
		close_out();
	end
	initial begin
		#5000000;
		num_errors++;
		close_out();
	end
endmodule : test_wake_watchdog_reset_sequencer
`default_nettype wire
